//--- core/dcp_cfg.svh
// constants of the two-wire control-port slave
`ifndef DCP_CFG_SVH
`define DCP_CFG_SVH

// ------------------------------------------------------------
// bus address and subaddress map
// ------------------------------------------------------------
`define DCP_DEV_ADDR_HI 6'h0A
`define DCP_SUB_MAX 12'hA56
`define DCP_SUB_PROG 12'h400
`define DCP_SUB_SAFE_ADR 12'hA45
`define DCP_SUB_CAPT 12'hA4A
`define DCP_SUB_CAPT_OUT 12'hA50
`define DCP_SUB_RAMCFG 12'hA53
`define DCP_SUB_SIN 12'hA56

// ------------------------------------------------------------
// word lengths in bytes
// ------------------------------------------------------------
`define DCP_LEN_PARAM 3'h4
`define DCP_LEN_PROG 3'h5
`define DCP_LEN_REG 3'h2
`define DCP_LEN_BYTE 3'h1
`define DCP_LEN_CAPT_RD 3'h3

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define DCP_SPIKE_NS 50
`define DCP_CLK_PS 4000
`define DCP_SPIKE_CYC ((`DCP_SPIKE_NS * 1000 + `DCP_CLK_PS - 1) / `DCP_CLK_PS)

`endif

//--- core/dcp_pkg.sv
// types of the two-wire control-port slave
package dcp_pkg;

    typedef enum logic [2:0] {
        DCP_IDLE = 3'h0,
        DCP_RX = 3'h1,
        DCP_SACK = 3'h2,
        DCP_TX = 3'h3,
        DCP_MACK = 3'h4
    } dcp_state_t;

    typedef enum logic [1:0] {
        DCP_PH_ADDR = 2'h0,
        DCP_PH_SUBH = 2'h1,
        DCP_PH_SUBL = 2'h2,
        DCP_PH_DATA = 2'h3
    } dcp_phase_t;

    typedef struct packed {
        logic we;
        logic [11:0] addr;
        logic [39:0] wdata;
    } dcp_req_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic val;
        logic [7:0] cnt;
    } dcp_filt_t;

    typedef struct packed {
        logic fd_s1;
        logic fd_s2;
        logic as_s1;
        logic as_s2;
        logic ack_s1;
        logic ack_s2;
        logic ack_d;
        logic scl_d;
        logic sda_d;
        dcp_state_t state;
        dcp_phase_t phase;
        logic rw;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [11:0] sub;
        logic ovf;
        logic [2:0] bidx;
        logic [39:0] word;
        logic [7:0] txb;
        logic [39:0] rword;
        dcp_req_t req;
        logic req_t;
        logic sda_en;
    } dcp_eng_t;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_d;
        logic req_out;
        logic pend;
        dcp_req_t op;
        logic [39:0] rdata;
        logic ack_t;
    } dcp_mem_t;

endpackage

//--- core/dcp_spike_filter.sv
// synchroniser and spike filter for one bus line
`timescale 1ns/1ps
`include "dcp_cfg.svh"

module dcp_spike_filter #(
    parameter int unsigned FILT_CYC = `DCP_SPIKE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic line,
    input wire logic bypass,
    output logic clean
);
    import dcp_pkg::*;

    dcp_filt_t r;
    dcp_filt_t n;

    always_comb begin
        n = r;
        n.s1 = line;
        n.s2 = r.s1;
        n.cnt = 8'h00;
        if (bypass) begin
            n.val = r.s2;
        end else if (r.s2 != r.val) begin
            // a new level is taken only once it has lasted the full spike width
            if (r.cnt == 8'(FILT_CYC - 1)) begin
                n.val = r.s2;
            end else begin
                n.cnt = r.cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r <= '0;
            r.s1 <= 1'b1;
            r.s2 <= 1'b1;
            r.val <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign clean = r.val;

    chk_filter_width: assert property (@(posedge clock) disable iff (rst)
        (!bypass && !$past(bypass) && $changed(r.val)) |-> $past(r.cnt) == 8'(FILT_CYC - 1))
        else $error("filtered line changed before the spike width elapsed");

endmodule

//--- core/dcp_i2c_slave.sv
// two-wire control-port slave with a memory-side access port
`timescale 1ns/1ps
`include "dcp_cfg.svh"

module dcp_i2c_slave #(
    parameter int unsigned FILT_CYC = `DCP_SPIKE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic scl_line,
    input wire logic sda_line,
    output logic sda_pull,
    output logic sda_en,
    input wire logic adr_sel_pin,
    input wire logic glitch_filter_disable_pin,
    input wire logic mem_clk,
    input wire logic mem_rst,
    output logic mem_req,
    output dcp_pkg::dcp_req_t mem_op,
    input wire logic [39:0] mem_rdata
);
    import dcp_pkg::*;

    // ------------------------------------------------------------
    // word length decode and byte pick
    // ------------------------------------------------------------
    function automatic logic [2:0] word_len(input logic [11:0] a, input logic rd);
        if (a < `DCP_SUB_PROG) begin
            return `DCP_LEN_PARAM;
        end else if (a < `DCP_SUB_SAFE_ADR) begin
            return `DCP_LEN_PROG;
        end else if (a < `DCP_SUB_CAPT) begin
            return `DCP_LEN_REG;
        end else if (a < `DCP_SUB_CAPT_OUT) begin
            return rd ? `DCP_LEN_CAPT_RD : `DCP_LEN_REG;
        end else if (a == `DCP_SUB_RAMCFG || a == `DCP_SUB_SIN) begin
            return `DCP_LEN_BYTE;
        end
        return `DCP_LEN_REG;
    endfunction

    // bytes go out most significant first from a right-aligned word
    function automatic logic [7:0] pick_byte(input logic [39:0] w, input logic [2:0] len,
                                             input logic [2:0] idx);
        logic [2:0] k;
        k = len - idx - 3'h1;
        return w[{k, 3'h0} +: 8];
    endfunction

    // ------------------------------------------------------------
    // line conditioning
    // ------------------------------------------------------------
    dcp_eng_t e;
    dcp_eng_t n;
    dcp_mem_t m;
    dcp_mem_t nm;
    logic scl_c;
    logic sda_c;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic addr_hit;
    logic [2:0] wlen_w;
    logic [2:0] wlen_r;

    dcp_spike_filter #(.FILT_CYC(FILT_CYC)) u_scl_filt (
        .clock(clock),
        .rst(rst),
        .line(scl_line),
        .bypass(e.fd_s2),
        .clean(scl_c)
    );

    dcp_spike_filter #(.FILT_CYC(FILT_CYC)) u_sda_filt (
        .clock(clock),
        .rst(rst),
        .line(sda_line),
        .bypass(e.fd_s2),
        .clean(sda_c)
    );

    assign scl_rise = scl_c & ~e.scl_d;
    assign scl_fall = ~scl_c & e.scl_d;
    assign start_ev = e.scl_d & scl_c & e.sda_d & ~sda_c;
    assign stop_ev = e.scl_d & scl_c & ~e.sda_d & sda_c;
    assign addr_hit = e.shreg[7:1] == {`DCP_DEV_ADDR_HI, e.as_s2};
    assign wlen_w = word_len(e.sub, 1'b0);
    assign wlen_r = word_len(e.sub, 1'b1);

    // ------------------------------------------------------------
    // bus engine
    // ------------------------------------------------------------
    always_comb begin
        logic top;
        logic [11:0] adv_sub;
        logic [7:0] b;
        top = e.sub == `DCP_SUB_MAX;
        adv_sub = top ? e.sub : e.sub + 12'h001;
        b = 8'h00;
        n = e;
        n.fd_s1 = glitch_filter_disable_pin;
        n.fd_s2 = e.fd_s1;
        n.as_s1 = adr_sel_pin;
        n.as_s2 = e.as_s1;
        n.ack_s1 = m.ack_t;
        n.ack_s2 = e.ack_s1;
        n.ack_d = e.ack_s2;
        n.scl_d = scl_c;
        n.sda_d = sda_c;
        if (e.ack_s2 != e.ack_d) begin
            n.rword = m.rdata;
        end
        if (stop_ev) begin
            n.state = DCP_IDLE;
            n.sda_en = 1'b0;
        end else if (start_ev) begin
            n.state = DCP_RX;
            n.phase = DCP_PH_ADDR;
            n.cnt = 4'h0;
            n.sda_en = 1'b0;
        end else begin
            unique case (e.state)
                DCP_IDLE: begin
                    n.sda_en = 1'b0;
                end
                DCP_RX: begin
                    if (scl_rise) begin
                        n.shreg = {e.shreg[6:0], sda_c};
                        n.cnt = e.cnt + 4'h1;
                    end else if (scl_fall && e.cnt == 4'h8) begin
                        n.state = DCP_SACK;
                        n.sda_en = 1'b1;
                        unique case (e.phase)
                            DCP_PH_ADDR: begin
                                n.rw = e.shreg[0];
                                n.phase = e.shreg[0] ? DCP_PH_DATA : DCP_PH_SUBH;
                                n.bidx = 3'h0;
                                if (!addr_hit) begin
                                    n.state = DCP_IDLE;
                                    n.sda_en = 1'b0;
                                end else if (e.shreg[0]) begin
                                    n.req = '{we: 1'b0, addr: e.sub, wdata: 40'h0};
                                    n.req_t = ~e.req_t;
                                end
                            end
                            DCP_PH_SUBH: begin
                                n.sub[11:8] = e.shreg[3:0];
                                n.phase = DCP_PH_SUBL;
                            end
                            DCP_PH_SUBL: begin
                                n.sub[7:0] = e.shreg;
                                n.phase = DCP_PH_DATA;
                                n.bidx = 3'h0;
                                n.word = 40'h0;
                                n.ovf = 1'b0;
                                if ({e.sub[11:8], e.shreg} > `DCP_SUB_MAX) begin
                                    n.state = DCP_IDLE;
                                    n.sda_en = 1'b0;
                                end
                            end
                            DCP_PH_DATA: begin
                                if (e.ovf) begin
                                    n.state = DCP_IDLE;
                                    n.sda_en = 1'b0;
                                end else if (e.bidx + 3'h1 == wlen_w) begin
                                    n.req = '{we: 1'b1, addr: e.sub,
                                              wdata: {e.word[31:0], e.shreg}};
                                    n.req_t = ~e.req_t;
                                    n.word = 40'h0;
                                    n.bidx = 3'h0;
                                    n.sub = adv_sub;
                                    n.ovf = top;
                                end else begin
                                    n.word = {e.word[31:0], e.shreg};
                                    n.bidx = e.bidx + 3'h1;
                                end
                            end
                        endcase
                    end
                end
                DCP_SACK: begin
                    if (scl_fall) begin
                        n.cnt = 4'h0;
                        if (e.rw) begin
                            b = pick_byte(e.rword, wlen_r, e.bidx);
                            n.state = DCP_TX;
                            n.txb = b;
                            n.sda_en = ~b[7];
                        end else begin
                            n.state = DCP_RX;
                            n.sda_en = 1'b0;
                        end
                    end
                end
                DCP_TX: begin
                    if (scl_fall) begin
                        if (e.cnt == 4'h7) begin
                            n.state = DCP_MACK;
                            n.sda_en = 1'b0;
                        end else begin
                            n.txb = {e.txb[6:0], 1'b0};
                            n.cnt = e.cnt + 4'h1;
                            n.sda_en = ~e.txb[6];
                        end
                    end
                end
                DCP_MACK: begin
                    if (scl_rise) begin
                        if (sda_c) begin
                            n.state = DCP_IDLE;
                        end else if (e.bidx + 3'h1 == wlen_r) begin
                            n.bidx = 3'h0;
                            n.sub = adv_sub;
                            n.ovf = top;
                            n.req = '{we: 1'b0, addr: adv_sub, wdata: 40'h0};
                            n.req_t = ~e.req_t;
                        end else begin
                            n.bidx = e.bidx + 3'h1;
                        end
                    end else if (scl_fall) begin
                        b = pick_byte(e.rword, wlen_r, e.bidx);
                        n.state = DCP_TX;
                        n.cnt = 4'h0;
                        n.txb = b;
                        n.sda_en = ~b[7];
                    end
                end
                default: begin
                    n.state = DCP_IDLE;
                    n.sda_en = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            e <= '0;
            e.scl_d <= 1'b1;
            e.sda_d <= 1'b1;
        end else begin
            e <= n;
        end
    end

    assign sda_pull = 1'b0;
    assign sda_en = e.sda_en;

    // ------------------------------------------------------------
    // memory-side domain: toggle request in, toggle answer out
    // ------------------------------------------------------------
    always_comb begin
        nm = m;
        nm.req_s1 = e.req_t;
        nm.req_s2 = m.req_s1;
        nm.req_d = m.req_s2;
        nm.req_out = 1'b0;
        nm.pend = 1'b0;
        // request fields stay still in the engine until its next toggle
        if (m.req_s2 != m.req_d) begin
            nm.req_out = 1'b1;
            nm.op = e.req;
            nm.pend = ~e.req.we;
        end
        if (m.pend) begin
            nm.rdata = mem_rdata;
            nm.ack_t = ~m.ack_t;
        end
    end

    always_ff @(posedge mem_clk) begin
        if (mem_rst) begin
            m <= '0;
        end else begin
            m <= nm;
        end
    end

    assign mem_req = m.req_out;
    assign mem_op = m.op;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_byte_end;
        e.state == DCP_RX && scl_fall && e.cnt == 4'h8 && !start_ev && !stop_ev;
    endsequence

    sequence s_data_end;
        s_byte_end ##0 e.phase == DCP_PH_DATA;
    endsequence

    chk_idle_quiet: assert property (@(posedge clock) disable iff (rst)
        e.state == DCP_IDLE |-> !e.sda_en)
        else $error("bus driven while idle");

    chk_addr_ack: assert property (@(posedge clock) disable iff (rst)
        (s_byte_end ##0 e.phase == DCP_PH_ADDR && addr_hit) |=> e.state == DCP_SACK && e.sda_en)
        else $error("matching address not acknowledged");

    chk_addr_miss: assert property (@(posedge clock) disable iff (rst)
        (s_byte_end ##0 e.phase == DCP_PH_ADDR && !addr_hit) |=> e.state == DCP_IDLE && !e.sda_en)
        else $error("foreign address answered");

    chk_dir_bit: assert property (@(posedge clock) disable iff (rst)
        (s_byte_end ##0 e.phase == DCP_PH_ADDR && addr_hit) |=> e.rw == $past(e.shreg[0]))
        else $error("direction not taken from address lsb");

    chk_start_any: assert property (@(posedge clock) disable iff (rst)
        start_ev && !stop_ev |=> e.state == DCP_RX && e.phase == DCP_PH_ADDR && e.cnt == 4'h0)
        else $error("start not restarting address phase");

    chk_stop_idle: assert property (@(posedge clock) disable iff (rst)
        stop_ev |=> e.state == DCP_IDLE && !e.sda_en ##1 e.state == DCP_IDLE || start_ev)
        else $error("stop not returning to idle");

    chk_bad_sub: assert property (@(posedge clock) disable iff (rst)
        (s_byte_end ##0 e.phase == DCP_PH_SUBL && {e.sub[11:8], e.shreg} > `DCP_SUB_MAX)
        |=> e.state == DCP_IDLE && !e.sda_en)
        else $error("invalid subaddress acknowledged");

    chk_wr_discard: assert property (@(posedge clock) disable iff (rst)
        (s_data_end ##0 e.ovf) |=> e.state == DCP_IDLE && !e.sda_en && $stable(e.req_t))
        else $error("overrun write byte not discarded");

    chk_wr_incr: assert property (@(posedge clock) disable iff (rst)
        (s_data_end ##0 !e.ovf && e.bidx + 3'h1 == wlen_w && e.sub != `DCP_SUB_MAX)
        |=> e.sub == $past(e.sub) + 12'h001 && e.req_t != $past(e.req_t) && e.bidx == 3'h0)
        else $error("subaddress not advanced after full word");

    chk_rd_top: assert property (@(posedge clock) disable iff (rst)
        e.ovf && e.rw && e.state == DCP_MACK && scl_rise && !sda_c |=> e.sub == `DCP_SUB_MAX)
        else $error("read overrun left top location");

    chk_mem_pulse: assert property (@(posedge mem_clk) disable iff (mem_rst)
        mem_req && !mem_op.we |=> !mem_req && m.ack_t != $past(m.ack_t))
        else $error("read answer not returned one cycle after request");

endmodule

//--- test/dcp_bus_master.sv
// two-wire bus master model for the control-port slave
`timescale 1ns/1ps

module dcp_bus_master (
    input wire logic clock,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    localparam int HALF = 24;
    int spk = 0;

    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // ------------------------------------------------------------
    // bit, byte and framing tasks
    // ------------------------------------------------------------
    // data moves only in the low phase; optional short low spike in the high phase
    task automatic bit_x(input logic b, output logic got);
        tick(4);
        sda_low <= ~b;
        tick(HALF - 4);
        scl <= 1'b1;
        if (b && spk > 0) begin
            tick(8);
            sda_low <= 1'b1;
            tick(spk);
            sda_low <= 1'b0;
            tick(HALF - 8 - spk);
            spk = 0;
        end else begin
            tick(HALF);
        end
        got = sda;
        scl <= 1'b0;
    endtask

    task automatic start();
        tick(4);
        sda_low <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_low <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
    endtask

    task automatic stop();
        tick(4);
        sda_low <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_low <= 1'b0;
        tick(HALF);
    endtask

    // msb first, then the ninth pulse with the line released
    task automatic wr_byte(input logic [7:0] d, output logic nack);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], nack);
        end
        bit_x(1'b1, nack);
    endtask

    task automatic rd_byte(input logic ma, output logic [7:0] d);
        logic g;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(~ma, g);
    endtask
endmodule

//--- test/test_dcp_i2c_slave.sv
// self-checking bench for the two-wire control-port slave
`timescale 1ns/1ps

module test_dcp_i2c_slave;
    import dcp_pkg::*;
    logic clock = 1'b0;
    logic mem_clk = 1'b0;
    logic rst = 1'b1;
    logic mem_rst = 1'b1;
    logic adr_sel_pin = 1'b0;
    logic glitch_filter_disable_pin = 1'b0;
    logic [39:0] mem_rdata;
    logic scl, sda_low, sda_pull, sda_en, mem_req;
    dcp_req_t mem_op;
    dcp_req_t mq[$];
    int err_total = 0;
    int n_tests = 0;
    // pulled-up open-drain wire
    wire sda = ~(sda_low | (sda_en & ~sda_pull));

    always #2 clock = ~clock;
    always #3 mem_clk = ~mem_clk;

    dcp_i2c_slave #(.FILT_CYC(13)) i_dcp_i2c_slave (
        .clock(clock), .rst(rst), .scl_line(scl), .sda_line(sda),
        .sda_pull(sda_pull), .sda_en(sda_en), .adr_sel_pin(adr_sel_pin),
        .glitch_filter_disable_pin(glitch_filter_disable_pin),
        .mem_clk(mem_clk), .mem_rst(mem_rst), .mem_req(mem_req),
        .mem_op(mem_op), .mem_rdata(mem_rdata));

    dcp_bus_master i_dcp_bus_master (
        .clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));

    // ------------------------------------------------------------
    // memory side: logs requests, read data valid one cycle only
    // ------------------------------------------------------------
    function automatic logic [39:0] pat(input logic [11:0] a);
        return {a[7:0], a[7:0] + 8'h11, a[7:0] + 8'h22, a[7:0] + 8'h33, a[7:0] + 8'h44};
    endfunction

    always @(posedge mem_clk) begin
        if (mem_req) begin
            mq.push_back(mem_op);
        end
    end

    // the slave takes the word at the edge that ends its request pulse
    assign mem_rdata = mem_req ? pat(mem_op.addr) : ~pat(mem_op.addr);

    // ------------------------------------------------------------
    // checks and helpers
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_req(input logic we, input logic [11:0] a, input logic [39:0] d);
        dcp_req_t r;
        for (int i = 0; i < 300 && mq.size() == 0; i++) @(posedge clock);
        if (mq.size() == 0) begin
            err_total++;
            $display("MISMATCH mem_req expected request seen none");
            tally_and_finish();
        end else begin
            r = mq.pop_front();
            chk("mem_op addr", {27'h0, we, a}, {27'h0, r.we, r.addr});
            if (we) chk("mem_op wdata", d, r.wdata);
        end
    endtask

    task automatic chk_n(input int n);
        chk("request count", 40'(n), 40'(mq.size()));
    endtask

    task automatic t_start();
        i_dcp_bus_master.start();
    endtask

    task automatic t_stop();
        i_dcp_bus_master.stop();
        repeat (20) @(posedge clock);
        chk("sda_en idle", 40'h0, {39'h0, sda_en});
    endtask

    task automatic wr(input logic [7:0] d, input logic en);
        logic na;
        i_dcp_bus_master.wr_byte(d, na);
        chk("ack", {39'h0, en}, {39'h0, na});
    endtask

    task automatic rd(input logic [11:0] a, input int k, input logic ma);
        logic [7:0] d;
        logic [39:0] p;
        p = pat(a);
        i_dcp_bus_master.rd_byte(ma, d);
        chk("read byte", {32'h0, p[8*k +: 8]}, {32'h0, d});
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic sc_write_burst();
        t_start();
        wr(8'h28, 1'b0);
        wr(8'hFA, 1'b0);
        wr(8'h52, 1'b0);
        wr(8'h12, 1'b0);
        wr(8'h34, 1'b0);
        wr(8'h56, 1'b0);
        wr(8'h78, 1'b0);
        t_stop();
        chk_req(1'b1, 12'hA52, 40'h1234);
        chk_req(1'b1, 12'hA53, 40'h56);
        chk_n(0);
    endtask

    task automatic sc_addr();
        for (int p = 0; p < 2; p++) begin
            adr_sel_pin <= p[0];
            repeat (20) @(posedge clock);
            for (int a = 0; a < 2; a++) begin
                t_start();
                wr(8'h28 | 8'(a * 2), a != p);
                wr(8'h0A, a != p);
                t_stop();
            end
        end
        adr_sel_pin <= 1'b0;
    endtask

    task automatic sc_bad_sub();
        t_start();
        wr(8'h28, 1'b0);
        wr(8'h0A, 1'b0);
        wr(8'h57, 1'b1);
        wr(8'h00, 1'b1);
        t_stop();
        chk_n(0);
    endtask

    task automatic sc_overrun_wr();
        t_start();
        wr(8'h28, 1'b0);
        wr(8'h0A, 1'b0);
        wr(8'h56, 1'b0);
        wr(8'h11, 1'b0);
        wr(8'h22, 1'b1);
        wr(8'h33, 1'b1);
        t_stop();
        chk_req(1'b1, 12'hA56, 40'h11);
        chk_n(0);
    endtask

    task automatic sc_read();
        t_start();
        wr(8'h28, 1'b0);
        wr(8'h0A, 1'b0);
        wr(8'h55, 1'b0);
        t_start();
        wr(8'h29, 1'b0);
        rd(12'hA55, 1, 1'b1);
        rd(12'hA55, 0, 1'b1);
        rd(12'hA56, 0, 1'b1);
        rd(12'hA56, 0, 1'b1);
        rd(12'hA56, 0, 1'b0);
        t_stop();
        chk_req(1'b0, 12'hA55, 40'h0);
        chk_req(1'b0, 12'hA56, 40'h0);
        chk_req(1'b0, 12'hA56, 40'h0);
        chk_req(1'b0, 12'hA56, 40'h0);
        chk_n(0);
    endtask

    task automatic sc_abort();
        logic g;
        t_start();
        wr(8'h28, 1'b0);
        wr(8'h0A, 1'b0);
        wr(8'h52, 1'b0);
        for (int i = 0; i < 4; i++) i_dcp_bus_master.bit_x(1'b1, g);
        t_start();
        wr(8'h28, 1'b0);
        wr(8'h0A, 1'b0);
        wr(8'h53, 1'b0);
        wr(8'h9A, 1'b0);
        t_stop();
        chk_req(1'b1, 12'hA53, 40'h9A);
        chk_n(0);
    endtask

    // a 40 ns low spike inside a one bit: dropped when filtered, a start/stop when not
    task automatic sc_spike(input logic byp);
        glitch_filter_disable_pin <= byp;
        repeat (20) @(posedge clock);
        t_start();
        wr(8'h28, 1'b0);
        wr(8'h0A, 1'b0);
        wr(8'h53, 1'b0);
        i_dcp_bus_master.spk = 10;
        wr(8'hFF, byp);
        t_stop();
        if (!byp) chk_req(1'b1, 12'hA53, 40'hFF);
        chk_n(0);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        mem_rst <= 1'b0;
        repeat (40) @(posedge clock);
        sc_write_burst();
        sc_addr();
        sc_bad_sub();
        sc_overrun_wr();
        sc_read();
        sc_abort();
        sc_spike(1'b0);
        sc_spike(1'b1);
        tally_and_finish();
    end
endmodule
